// ---- logic/pif_pkg.sv ----
/*
 * Constants for the interrupt flag and mask block of the power manager:
 * register offsets, field positions, reset values and synchroniser depth.
 * Assumes one system clock and a register port driven by the serial
 * management engine, which decodes the wire protocol elsewhere.
 */
// Summary of operation
// - Switch status bit 5 set when switch three overheats and shuts down.
// - Switch status bit 4 set on switch two overheat or input undervoltage.
// - Switch status bit 3 set when switch one overheats and shuts down.
// - Switch status bits 2 to 0 show switches three to one limiting current.
// - System mask holds six bits masking the six system events in order.
// - Switch mask bits 5-3 mask faults, bits 2-0 mask current limits.
// - A clear mask bit lets its event pull the interrupt pin low.
// - A set mask bit keeps its event away from the interrupt pin.
// - Masking never stops monitoring; status flags record regardless.
// - Switch status at 0x02 resets to zero; bits 7-6 read zero, read-only.
// - All mask bits reset to zero and are host readable and writable.
// - System status reports six system events from bit 5 down to bit 0.
package pif_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int EVT_W = 6;
    localparam int SW_N = 3;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_SYS_STATUS = 8'h01;
    localparam logic [7:0] OFS_SWITCH_STATUS = 8'h02;
    localparam logic [7:0] OFS_SYS_MASK = 8'h03;
    localparam logic [7:0] OFS_SWITCH_MASK = 8'h04;

    // ----------------------------------------------------------------
    // Reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [5:0] RST_FLAGS = 6'h00;
    localparam logic [5:0] RST_MASK = 6'h00;
    localparam logic [7:0] RST_RDATA = 8'h00;
    localparam logic [1:0] RSVD_VALUE = 2'h0;
    localparam int POS_FAULT_LSB = 3;
    localparam int POS_ILIMIT_LSB = 0;
    localparam int POS_ADAPTER = 4;
    localparam int POS_PUSHBUTTON = 3;

    // ----------------------------------------------------------------
    // Event input synchroniser depth
    // ----------------------------------------------------------------
    localparam int SYNC_STAGES = 3;

endpackage

// ---- logic/pif_event_flag.sv ----
/*
 * One sticky event flag with its input synchroniser.
 * Assumes event_in comes from outside the clock domain and rst_n is an
 * already synchronised active-low reset.
 */
module pif_event_flag #(
    parameter bit EDGE_MODE = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic event_in,
    input wire logic clear,
    output logic set_pulse,
    output logic flag
);
    import pif_pkg::*;

    logic [SYNC_STAGES-1:0] sync;
    logic settled;
    logic agree;
    logic next_settled;
    logic next_flag;

    // ----------------------------------------------------------------
    // Synchroniser: a change counts once the last two stages agree.
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync <= '0;
            settled <= 1'b0;
        end else begin
            sync <= {sync[SYNC_STAGES-2:0], event_in};
            settled <= next_settled;
        end
    end

    assign agree = (sync[1] == sync[2]);
    assign next_settled = agree ? sync[2] : settled;

    // Change mode sets on either edge; level mode sets while high.
    assign set_pulse = EDGE_MODE ? (next_settled != settled) : settled;

    // ----------------------------------------------------------------
    // Sticky flag: a set in the clearing cycle wins.
    // ----------------------------------------------------------------
    assign next_flag = set_pulse | (flag & ~clear);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

endmodule

// ---- logic/pif_irq_ctrl.sv ----
/*
 * Interrupt flags, masks and the active-low interrupt pin of the power
 * manager. Holds the system and switch status registers, both mask
 * registers and the read-clear behaviour.
 * Assumes a register port from the serial management engine: one-cycle
 * read and write strobes with an address, on the same clock as mclk.
 * Event inputs are asynchronous levels from the analog monitors.
 */
module pif_irq_ctrl (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [pif_pkg::EVT_W-1:0] sys_event_in,
    input wire logic [pif_pkg::SW_N-1:0] switch_fault_in,
    input wire logic [pif_pkg::SW_N-1:0] switch_ilimit_in,
    input wire logic [pif_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [pif_pkg::DATA_W-1:0] reg_wdata,
    output logic [pif_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output logic irq_out_low,
    output logic irq_out_low_oe
);
    import pif_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_pipe;
    logic rst_sync_b;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_sync_b = rst_pipe[1];

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire hit_sys_status = (reg_addr == OFS_SYS_STATUS);
    wire hit_sw_status = (reg_addr == OFS_SWITCH_STATUS);
    wire hit_sys_mask = (reg_addr == OFS_SYS_MASK);
    wire hit_sw_mask = (reg_addr == OFS_SWITCH_MASK);

    wire clr_sys = reg_rd & hit_sys_status;
    wire clr_sw = reg_rd & hit_sw_status;
    wire wr_sys_mask = reg_wr & hit_sys_mask;
    wire wr_sw_mask = reg_wr & hit_sw_mask;

    // ----------------------------------------------------------------
    // Event flags
    // ----------------------------------------------------------------
    logic [EVT_W-1:0] sys_flags;
    logic [EVT_W-1:0] sys_set;
    logic [EVT_W-1:0] sw_flags;
    logic [EVT_W-1:0] sw_set;
    logic [EVT_W-1:0] sw_event_in;

    // Faults of switches three..one above their current limits.
    assign sw_event_in = {switch_fault_in, switch_ilimit_in};

    genvar gi;
    generate
        for (gi = 0; gi < EVT_W; gi = gi + 1) begin : g_evt
            // Adapter and push-button bits record pin changes.
            localparam bit IS_EDGE = (gi == POS_ADAPTER) ||
                (gi == POS_PUSHBUTTON);

            pif_event_flag #(
                .EDGE_MODE(IS_EDGE)
            ) u_sys_flag (
                .mclk(mclk),
                .rst_n(rst_sync_b),
                .event_in(sys_event_in[gi]),
                .clear(clr_sys),
                .set_pulse(sys_set[gi]),
                .flag(sys_flags[gi])
            );

            // Fault bits 5..3 and current-limit bits 2..0.
            pif_event_flag #(
                .EDGE_MODE(1'b0)
            ) u_sw_flag (
                .mclk(mclk),
                .rst_n(rst_sync_b),
                .event_in(sw_event_in[gi]),
                .clear(clr_sw),
                .set_pulse(sw_set[gi]),
                .flag(sw_flags[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Mask registers
    // ----------------------------------------------------------------
    logic [EVT_W-1:0] sys_mask;
    logic [EVT_W-1:0] sw_mask;

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sys_mask <= RST_MASK;
            sw_mask <= RST_MASK;
        end else begin
            if (wr_sys_mask) begin
                sys_mask <= reg_wdata[EVT_W-1:0];
            end
            if (wr_sw_mask) begin
                sw_mask <= reg_wdata[EVT_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Status is captured before the read clears it, so no event is lost.
    wire [EVT_W-1:0] rd_field = hit_sys_status ? sys_flags :
        hit_sw_status ? sw_flags :
        hit_sys_mask ? sys_mask :
        hit_sw_mask ? sw_mask : RST_FLAGS;
    wire [DATA_W-1:0] next_rdata = {RSVD_VALUE, rd_field};

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            reg_rdata <= RST_RDATA;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt pin
    // ----------------------------------------------------------------
    wire [EVT_W-1:0] sys_pending = sys_flags & ~sys_mask;
    wire [EVT_W-1:0] sw_pending = sw_flags & ~sw_mask;
    wire any_pending = (|sys_pending) | (|sw_pending);

    // The pin is open drain: driven low while pending, released otherwise.
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            irq_out_low <= 1'b1;
            irq_out_low_oe <= 1'b0;
        end else begin
            irq_out_low <= ~any_pending;
            irq_out_low_oe <= any_pending;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_sw_status_read;
        reg_rd && hit_sw_status;
    endsequence

    sequence s_read_answer;
        reg_rvalid && (reg_rdata[DATA_W-1:EVT_W] == RSVD_VALUE);
    endsequence

    property p_pin_low_on_pending;
        @(posedge mclk) disable iff (!rst_sync_b)
        any_pending |=> !irq_out_low && irq_out_low_oe;
    endproperty
    a_pin_low_on_pending: assert property (p_pin_low_on_pending)
        else $error("Unmasked flag did not pull interrupt pin low.");

    property p_masked_no_effect;
        @(posedge mclk) disable iff (!rst_sync_b)
        ((sys_flags & ~sys_mask) == 6'h00 &&
            (sw_flags & ~sw_mask) == 6'h00) |=> irq_out_low;
    endproperty
    a_masked_no_effect: assert property (p_masked_no_effect)
        else $error("Masked flags still drive the interrupt pin.");

    property p_record_when_masked;
        @(posedge mclk) disable iff (!rst_sync_b)
        (|sw_set) |=> ((sw_flags & $past(sw_set)) == $past(sw_set));
    endproperty
    a_record_when_masked: assert property (p_record_when_masked)
        else $error("Switch event was not recorded in status.");

    property p_sw_read_answer;
        @(posedge mclk) disable iff (!rst_sync_b)
        s_sw_status_read |=> s_read_answer ##0
            (reg_rdata[EVT_W-1:0] == $past(sw_flags));
    endproperty
    a_sw_read_answer: assert property (p_sw_read_answer)
        else $error("Switch status read returned wrong data.");

    property p_read_clears;
        @(posedge mclk) disable iff (!rst_sync_b)
        s_sw_status_read ##0 (sw_set == 6'h00) |=> sw_flags == 6'h00;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("Switch status flags survived a read.");

    property p_mask_write;
        @(posedge mclk) disable iff (!rst_sync_b)
        wr_sys_mask |=> sys_mask == $past(reg_wdata[EVT_W-1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("System mask write was not stored.");

    property p_sw_mask_readback;
        @(posedge mclk) disable iff (!rst_sync_b)
        wr_sw_mask ##1 !reg_wr ##1 (reg_rd && hit_sw_mask && !reg_wr) |=>
            reg_rvalid &&
            reg_rdata == {RSVD_VALUE, $past(reg_wdata[EVT_W-1:0], 3)};
    endproperty
    a_sw_mask_readback: assert property (p_sw_mask_readback)
        else $error("Switch mask did not read back as written.");

    property p_mask_reset;
        @(posedge mclk)
        $rose(rst_sync_b) |-> sys_mask == 6'h00 && sw_mask == 6'h00;
    endproperty
    a_mask_reset: assert property (p_mask_reset)
        else $error("Mask registers not zero after reset.");

    property p_fault_pin_to_flag;
        @(posedge mclk) disable iff (!rst_sync_b)
        switch_fault_in[2] [*5] |-> ##[0:2] sw_flags[5];
    endproperty
    a_fault_pin_to_flag: assert property (p_fault_pin_to_flag)
        else $error("Switch three fault did not set its flag.");

    property p_sys_read_answer;
        @(posedge mclk) disable iff (!rst_sync_b)
        reg_rd && hit_sys_status |=> s_read_answer ##0
            (reg_rdata[EVT_W-1:0] == $past(sys_flags));
    endproperty
    a_sys_read_answer: assert property (p_sys_read_answer)
        else $error("System status read returned wrong data.");

    property p_pin_release;
        @(posedge mclk) disable iff (!rst_sync_b)
        !any_pending |=> irq_out_low && !irq_out_low_oe;
    endproperty
    a_pin_release: assert property (p_pin_release)
        else $error("Interrupt pin still driven with nothing pending.");

    property p_sw_mask_write;
        @(posedge mclk) disable iff (!rst_sync_b)
        wr_sw_mask |=> sw_mask == $past(reg_wdata[EVT_W-1:0]);
    endproperty
    a_sw_mask_write: assert property (p_sw_mask_write)
        else $error("Switch mask write was not stored.");

    property p_status_read_only;
        @(posedge mclk) disable iff (!rst_sync_b)
        reg_wr && !reg_rd && (hit_sys_status || hit_sw_status) &&
            sys_set == 6'h00 && sw_set == 6'h00 |=>
            $stable(sys_flags) && $stable(sw_flags);
    endproperty
    a_status_read_only: assert property (p_status_read_only)
        else $error("A write changed a status register.");

    property p_sys_record;
        @(posedge mclk) disable iff (!rst_sync_b)
        (|sys_set) |=> ((sys_flags & $past(sys_set)) == $past(sys_set));
    endproperty
    a_sys_record: assert property (p_sys_record)
        else $error("System event was not recorded in status.");

    property p_sys_read_clears;
        @(posedge mclk) disable iff (!rst_sync_b)
        reg_rd && hit_sys_status ##0 (sys_set == 6'h00) |=> sys_flags == 6'h00;
    endproperty
    a_sys_read_clears: assert property (p_sys_read_clears)
        else $error("System status flags survived a read.");

    property p_sw2_fault_to_flag;
        @(posedge mclk) disable iff (!rst_sync_b)
        switch_fault_in[1] [*5] |-> ##[0:2] sw_flags[4];
    endproperty
    a_sw2_fault_to_flag: assert property (p_sw2_fault_to_flag)
        else $error("Switch two fault did not set its flag.");

    property p_sw1_fault_to_flag;
        @(posedge mclk) disable iff (!rst_sync_b)
        switch_fault_in[0] [*5] |-> ##[0:2] sw_flags[3];
    endproperty
    a_sw1_fault_to_flag: assert property (p_sw1_fault_to_flag)
        else $error("Switch one fault did not set its flag.");

    property p_ilimit_to_flag;
        @(posedge mclk) disable iff (!rst_sync_b)
        switch_ilimit_in[0] [*5] |-> ##[0:2] sw_flags[0];
    endproperty
    a_ilimit_to_flag: assert property (p_ilimit_to_flag)
        else $error("Switch one current limit did not set its flag.");

    property p_rvalid_quiet;
        @(posedge mclk) disable iff (!rst_sync_b)
        !reg_rd |=> !reg_rvalid;
    endproperty
    a_rvalid_quiet: assert property (p_rvalid_quiet)
        else $error("Read answer appeared without a read.");

endmodule

// ---- tb/pif_host_model.sv ----
/*
 * Host processor model that reaches the interrupt registers through the
 * register strobe port standing in for the serial management engine.
 * Assumes the bench calls its tasks and shares mclk with the design.
 */
module pif_host_model (
    input wire logic mclk,
    output logic [pif_pkg::ADDR_W-1:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [pif_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [pif_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    import pif_pkg::*;

    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        // Released data is inverted so stale values never look valid.
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output bit ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge mclk);
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                ok = 1'b1;
            end
        end
    endtask

    // The host learns the cause by reading both status registers.
    task automatic service(output logic [7:0] s1, output logic [7:0] s2,
                           output bit ok);
        bit ok2;
        rd(OFS_SYS_STATUS, s1, ok);
        rd(OFS_SWITCH_STATUS, s2, ok2);
        ok = ok & ok2;
    endtask
endmodule

// ---- tb/testbench.sv ----
/*
 * Self-checking bench for the interrupt flag and mask block.
 * Assumes the host model drives the register port and the bench drives
 * the event levels; the open-drain pin is pulled up here.
 */
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pif_pkg::*;

    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] ev = 12'h000;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic irq_out_low;
    logic irq_out_low_oe;
    int errors = 0;
    int n_checks = 0;
    wire pin = irq_out_low_oe ? irq_out_low : 1'b1;

    always #2.5 mclk = ~mclk;

    pif_irq_ctrl u_pif_irq_ctrl (.mclk(mclk), .rst_b(rst_b),
        .sys_event_in(ev[11:6]), .switch_fault_in(ev[5:3]),
        .switch_ilimit_in(ev[2:0]), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .irq_out_low(irq_out_low), .irq_out_low_oe(irq_out_low_oe));

    pif_host_model u_pif_host_model (.mclk(mclk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        bit ok;
        u_pif_host_model.rd(a, d, ok);
        if (!ok) begin
            errors++;
            results();
        end
        `CHK("read data", e, d)
    endtask

    task automatic wait_pin(input logic v);
        for (int i = 0; i < 30; i++) begin
            @(posedge mclk);
            if (pin === v)
                return;
        end
        `CHK("interrupt pin", v, pin)
        results();
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        for (int a = 1; a < 8; a++)
            rdc(a[7:0], 8'h00);
        u_pif_host_model.wr(OFS_SWITCH_STATUS, 8'hFF);
        rdc(OFS_SWITCH_STATUS, 8'h00);
        `CHK("pin idle", 1'b1, pin)
        $display("test reset done");
    endtask

    task automatic t_events;
        logic [7:0] a;
        logic [7:0] s1;
        logic [7:0] s2;
        bit ok;
        for (int i = 0; i < 12; i++) begin
            a = (i < 6) ? OFS_SWITCH_STATUS : OFS_SYS_STATUS;
            @(posedge mclk);
            ev <= 12'h001 << i;
            wait_pin(1'b0);
            `CHK("pin driven", 1'b1, irq_out_low_oe)
            ev <= 12'h000;
            repeat (10) @(posedge mclk);
            u_pif_host_model.service(s1, s2, ok);
            if (!ok) begin
                errors++;
                results();
            end
            `CHK("cause", 12'h001 << i, {s1[5:0], s2[5:0]})
            `CHK("reserved", 4'h0, {s1[7:6], s2[7:6]})
            rdc(a, 8'h00);
            wait_pin(1'b1);
        end
        $display("test events done");
    endtask

    task automatic t_mask;
        logic [7:0] ma;
        logic [7:0] sa;
        for (int m = 0; m < 2; m++) begin
            ma = m ? OFS_SWITCH_MASK : OFS_SYS_MASK;
            sa = m ? OFS_SWITCH_STATUS : OFS_SYS_STATUS;
            u_pif_host_model.wr(ma, 8'hFF);
            rdc(ma, 8'h3F);
            @(posedge mclk);
            ev <= m ? 12'h03F : 12'hFC0;
            repeat (15) @(posedge mclk);
            `CHK("pin masked", 1'b1, pin)
            rdc(sa, 8'h3F);
            u_pif_host_model.wr(ma, 8'h3E);
            wait_pin(1'b0);
            ev <= 12'h000;
            u_pif_host_model.wr(ma, 8'h3F);
            repeat (10) @(posedge mclk);
            `CHK("pin remasked", 1'b1, pin)
            rdc(sa, 8'h3F);
            rdc(sa, 8'h00);
            u_pif_host_model.wr(ma, 8'h00);
            rdc(ma, 8'h00);
            wait_pin(1'b1);
        end
        $display("test mask done");
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_events();
        t_mask();
        results();
    end
endmodule
